// ---- hw/pbarb_pkg.sv ----
/*
  Package for the bridge arbitration block: register offsets, field
  positions, reset values, timing counts and state types.
  Assumes a single 100 MHz clock and synchronous active-high reset.
*/
package pbarb_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] SEC_ARB_CTRL_OFS = 8'h48;
  localparam logic [7:0] PREEMPT_CTRL_OFS = 8'h4C;
  localparam int PARK_BRIDGE_BIT = 1;
  localparam int ARB_DISABLE_BIT = 0;
  localparam int LEVEL_LSB = 8;
  localparam int PREEMPT_EN_LSB = 28;
  localparam int PREEMPT_TIME_LSB = 0;
  localparam logic [31:0] SEC_ARB_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PREEMPT_CTRL_RST = 32'hF000_0000;
  localparam logic [3:0] PREEMPT_ON = 4'hF;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RETRY_BACKOFF_CLKS = 2;
  localparam int IDLE_GRANT_CLKS = 16;
  localparam int NUM_REQ = 5;
  localparam int BRIDGE_IDX = 0;
  typedef enum logic [1:0] {
    PB_IDLE = 2'b00,
    PB_PARK = 2'b01,
    PB_XFER = 2'b10,
    PB_BACKOFF = 2'b11
  } pbarb_pstate_t;
endpackage : pbarb_pkg

// ---- hw/pbarb_top.sv ----
/*
  Bridge bus arbitration: primary request/grant/park control and the
  internal secondary arbiter with two-level rotation, preemption,
  idle-grant timeout and parking.
  Assumes pins synchronous to CLOCK_I; transaction engines outside
  report queue state, start acceptance and target terminations.
*/
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Hold primary request while upstream queue pending
// - Drop request two clocks after retry/disconnect/abort
// - Request only after transaction fully queued
// - Start primary transaction cycle after grant
// - Park primary only granted, unrequested, idle
// - Release primary AD/CBE/PAR after grant removal
// - Start from park if grant held last cycle
// - Drive parity one cycle after AD/CBE
// - Arbiter serves bridge plus four masters
// - Two-level rotating priority, programmable levels
// - Withdraw master grant after 16 idle unused cycles; bridge grant exempt
// - Idle bus: gap cycle between grants
// - Busy bus: grant swap same cycle allowed
// - Preemption switchable, enabled after reset
// - Time-to-preempt 0..64 clocks, reset zero
// - Preempt holder after waiter exceeds time
// - Park secondary at last master
// - After reset park secondary at bridge
// - Control bit forces parking at bridge
// - Internal arbiter can be disabled
// - Secondary reset floats grant outputs
module pbarb_top (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Configuration access
  input wire logic CFG_WR_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [31:0] CFG_WDATA_I,
  output logic [31:0] CFG_RDATA_O,
  // Upstream queue and initiator engine
  input wire logic UP_PENDING_I,
  input wire logic UP_QUEUED_I,
  input wire logic UP_TERM_I,
  output logic UP_START_O,
  // Primary bus
  input wire logic UPSTREAM_GNT_N_I,
  input wire logic UPSTREAM_BUS_IDLE_I,
  output logic UPSTREAM_REQ_N_O,
  output logic UPSTREAM_FRAME_N_O,
  output logic UPSTREAM_AD_OE_O,
  output logic UPSTREAM_CMD_BYTE_EN_OE_O,
  output logic UPSTREAM_PARITY_OE_O,
  // Secondary bus
  input wire logic DOWNSTREAM_RST_I,
  input wire logic [3:0] DOWNSTREAM_REQ_N_I,
  input wire logic DOWNSTREAM_BRIDGE_REQ_I,
  input wire logic DOWNSTREAM_FRAME_N_I,
  input wire logic DOWNSTREAM_INITIATOR_READY_N_I,
  output logic [3:0] DOWNSTREAM_GNT_N_O,
  output logic [3:0] DOWNSTREAM_GNT_OE_O,
  output logic DOWNSTREAM_BRIDGE_GNT_O
);
  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [31:0] sec_ctrl_r;
  logic [31:0] pre_ctrl_r;
  wire wr_sec = CFG_WR_I && (CFG_ADDR_I == pbarb_pkg::SEC_ARB_CTRL_OFS);
  wire wr_pre = CFG_WR_I && (CFG_ADDR_I == pbarb_pkg::PREEMPT_CTRL_OFS);
  wire park_bridge = sec_ctrl_r[pbarb_pkg::PARK_BRIDGE_BIT];
  wire arb_off = sec_ctrl_r[pbarb_pkg::ARB_DISABLE_BIT];
  wire [4:0] level_hi = sec_ctrl_r[pbarb_pkg::LEVEL_LSB +: 5];
  wire preempt_en = (pre_ctrl_r[pbarb_pkg::PREEMPT_EN_LSB +: 4] == pbarb_pkg::PREEMPT_ON);
  wire [2:0] pre_sel = pre_ctrl_r[pbarb_pkg::PREEMPT_TIME_LSB +: 3];
  wire [6:0] pre_time = (pre_sel == 3'h0) ? 7'h00 : 7'(7'h01 << (pre_sel - 3'h1));
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      sec_ctrl_r <= pbarb_pkg::SEC_ARB_CTRL_RST;
      pre_ctrl_r <= pbarb_pkg::PREEMPT_CTRL_RST;
    end else begin
      if (wr_sec) sec_ctrl_r <= CFG_WDATA_I;
      if (wr_pre) pre_ctrl_r <= CFG_WDATA_I;
    end
  end
  logic [31:0] rdata_r;
  wire [31:0] rdata_nxt = (CFG_ADDR_I == pbarb_pkg::SEC_ARB_CTRL_OFS) ? sec_ctrl_r :
                          (CFG_ADDR_I == pbarb_pkg::PREEMPT_CTRL_OFS) ? pre_ctrl_r : 32'h0;
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) rdata_r <= 32'h0;
    else rdata_r <= rdata_nxt;
  end
  assign CFG_RDATA_O = rdata_r;
  // ************************************************************
  // Primary side
  // ************************************************************
  pbarb_pkg::pbarb_pstate_t pst_r, pst_nxt;
  logic [1:0] back_r;
  logic gnt_q_r;
  logic park_ad_r;
  logic par_r;
  wire gnt = !UPSTREAM_GNT_N_I;
  // Request only once fully queued, and not during backoff
  wire want = UP_PENDING_I && UP_QUEUED_I;
  wire req = want && (pst_r != pbarb_pkg::PB_BACKOFF);
  // Start the cycle after grant seen with request, or from park with grant held
  wire start = want && gnt && gnt_q_r && (pst_r == pbarb_pkg::PB_IDLE ||
               pst_r == pbarb_pkg::PB_PARK) && UPSTREAM_BUS_IDLE_I;
  wire park_ok = gnt && !req && UPSTREAM_BUS_IDLE_I;
  always_comb begin
    pst_nxt = pst_r;
    unique case (pst_r)
      pbarb_pkg::PB_IDLE,
      pbarb_pkg::PB_PARK: begin
        if (start) pst_nxt = pbarb_pkg::PB_XFER;
        else if (park_ok) pst_nxt = pbarb_pkg::PB_PARK;
        else pst_nxt = pbarb_pkg::PB_IDLE;
      end
      pbarb_pkg::PB_XFER: begin
        if (UP_TERM_I) pst_nxt = pbarb_pkg::PB_BACKOFF;
        else if (!want) pst_nxt = pbarb_pkg::PB_IDLE;
      end
      pbarb_pkg::PB_BACKOFF: begin
        if (back_r == 2'(pbarb_pkg::RETRY_BACKOFF_CLKS - 1)) pst_nxt = pbarb_pkg::PB_IDLE;
      end
    endcase
  end
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pst_r <= pbarb_pkg::PB_IDLE;
      back_r <= 2'h0;
      gnt_q_r <= 1'b0;
      park_ad_r <= 1'b0;
      par_r <= 1'b0;
    end else begin
      pst_r <= pst_nxt;
      back_r <= (pst_r == pbarb_pkg::PB_BACKOFF) ? 2'(back_r + 2'h1) : 2'h0;
      gnt_q_r <= gnt;
      park_ad_r <= (pst_nxt == pbarb_pkg::PB_PARK) && gnt;
      par_r <= park_ad_r && (pst_nxt == pbarb_pkg::PB_PARK) && gnt;
    end
  end
  assign UPSTREAM_REQ_N_O = !req;
  assign UP_START_O = start;
  assign UPSTREAM_FRAME_N_O = !start;
  assign UPSTREAM_AD_OE_O = park_ad_r;
  assign UPSTREAM_CMD_BYTE_EN_OE_O = park_ad_r;
  assign UPSTREAM_PARITY_OE_O = par_r;
  // ************************************************************
  // Secondary arbiter; index 0 is the bridge
  // ************************************************************
  localparam int N = pbarb_pkg::NUM_REQ;
  wire [N-1:0] rq = {~DOWNSTREAM_REQ_N_I, DOWNSTREAM_BRIDGE_REQ_I};
  wire sbusy = !DOWNSTREAM_FRAME_N_I || !DOWNSTREAM_INITIATOR_READY_N_I;
  wire sidle = !sbusy;
  logic [N-1:0] gnt_r;
  logic [2:0] last_hi_r, last_lo_r;
  logic [4:0] idle_cnt_r;
  logic [6:0] wait_r;
  logic started_r;
  // Fair rotation within each level: search from the one after the last winner
  function automatic logic [2:0] rr_pick(input logic [N-1:0] m, input logic [2:0] last);
    logic [2:0] idx;
    rr_pick = 3'h7;
    for (int k = N; k >= 1; k--) begin
      idx = 3'((int'(last) + k) % N);
      if (m[idx]) rr_pick = idx;
    end
  endfunction
  wire [2:0] pick_hi = rr_pick(rq & level_hi, last_hi_r);
  wire [2:0] pick_lo = rr_pick(rq & ~level_hi, last_lo_r);
  wire [2:0] winner = (pick_hi != 3'h7) ? pick_hi : pick_lo;
  wire [N-1:0] win_oh = (winner == 3'h7) ? '0 : N'(1 << winner);
  wire others = |(rq & ~gnt_r);
  wire holder_req = |(rq & gnt_r);
  wire timeout = sidle && (idle_cnt_r == 5'(pbarb_pkg::IDLE_GRANT_CLKS - 1)) && !gnt_r[0];
  wire preempt = preempt_en && others && (wait_r >= pre_time);
  wire [N-1:0] bridge_oh = N'(1 << pbarb_pkg::BRIDGE_IDX);
  logic [N-1:0] gnt_nxt;
  always_comb begin
    gnt_nxt = gnt_r;
    // Forced park still honours the idle-bus gap before the bridge grant
    if (park_bridge && !others) begin
      gnt_nxt = (sidle && gnt_r != '0 && gnt_r != bridge_oh) ? '0 : bridge_oh;
    end
    else if (gnt_r == '0) gnt_nxt = sidle && win_oh != '0 ? win_oh :
                                   (!started_r ? bridge_oh : '0);
    else if (timeout || (others && (!holder_req || preempt))) begin
      // Busy bus: swap in one cycle; idle bus: leave a gap cycle
      gnt_nxt = sbusy ? win_oh : '0;
    end
    // Otherwise keep the last master parked
  end
  always_ff @(posedge CLOCK_I) begin
    if (RST_I || DOWNSTREAM_RST_I) begin
      gnt_r <= 5'h01;
      last_hi_r <= 3'h0;
      last_lo_r <= 3'h0;
      idle_cnt_r <= 5'h0;
      wait_r <= 7'h0;
      started_r <= 1'b0;
    end else begin
      gnt_r <= gnt_nxt;
      if ((gnt_nxt & ~gnt_r) != '0 && winner != 3'h7) begin
        if (level_hi[winner]) last_hi_r <= winner;
        else last_lo_r <= winner;
      end
      // Bridge grant is exempt, so its parked time must not run the counter
      idle_cnt_r <= (gnt_nxt == gnt_r && sidle && gnt_r != '0 && !gnt_r[0]) ?
                    5'(idle_cnt_r + 5'h1) : 5'h0;
      wait_r <= (others && gnt_nxt == gnt_r && wait_r != 7'h7F) ? 7'(wait_r + 7'h1) : 7'h0;
      if (sbusy) started_r <= 1'b1;
    end
  end
  // Floated under secondary reset or when the external arbiter rules
  assign DOWNSTREAM_GNT_OE_O = (DOWNSTREAM_RST_I || arb_off) ? 4'h0 : 4'hF;
  assign DOWNSTREAM_GNT_N_O = ~gnt_r[N-1:1];
  assign DOWNSTREAM_BRIDGE_GNT_O = gnt_r[0] && !arb_off;
  // ************************************************************
  // Checks
  // ************************************************************
  AST_BACKOFF: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (pst_r == pbarb_pkg::PB_XFER && UP_TERM_I) |=> UPSTREAM_REQ_N_O [*2])
    else $error("Request not dropped for two clocks");
  AST_NOREQ_UNQUEUED: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !UP_QUEUED_I |-> UPSTREAM_REQ_N_O)
    else $error("Request before queueing complete");
  AST_PAR_LATE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(UPSTREAM_PARITY_OE_O) |-> $past(UPSTREAM_AD_OE_O))
    else $error("Parity driven before AD");
  AST_RELEASE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    UPSTREAM_GNT_N_I |=> !UPSTREAM_AD_OE_O)
    else $error("AD still driven after grant loss");
  AST_PARK_COND: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(UPSTREAM_AD_OE_O) |-> $past(!UPSTREAM_GNT_N_I && UPSTREAM_BUS_IDLE_I))
    else $error("Parked without grant or idle bus");
  AST_GAP: assert property (@(posedge CLOCK_I) disable iff (RST_I || DOWNSTREAM_RST_I)
    (sidle && gnt_r != '0 && gnt_nxt != gnt_r) |-> gnt_nxt == '0)
    else $error("Grant swapped on idle bus");
  AST_ONEHOT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $onehot0(gnt_r))
    else $error("More than one secondary grant");
  AST_TIMEOUT: assert property (@(posedge CLOCK_I) disable iff (RST_I || DOWNSTREAM_RST_I)
    idle_cnt_r <= 5'(pbarb_pkg::IDLE_GRANT_CLKS - 1))
    else $error("Idle grant held past sixteen");
  AST_FLOAT: assert property (@(posedge CLOCK_I)
    DOWNSTREAM_RST_I |-> DOWNSTREAM_GNT_OE_O == 4'h0)
    else $error("Grant driven during secondary reset");
  // ************************************************************
  // Primary request and parking checks
  // ************************************************************
  // A start must ride on a grant seen on two edges in a row

  AST_START_GNT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    UP_START_O |-> (!UPSTREAM_GNT_N_I && $past(!UPSTREAM_GNT_N_I)))
    else $error("Start without a held grant");

  AST_REQ_HOLD: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (UP_PENDING_I && UP_QUEUED_I && pst_r != pbarb_pkg::PB_BACKOFF) |-> !UPSTREAM_REQ_N_O)
    else $error("Request dropped while work pending");

  AST_PARK_GNT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    UPSTREAM_AD_OE_O |-> $past(!UPSTREAM_GNT_N_I))
    else $error("Parked without a grant");

  AST_START_PARK: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (UP_START_O && pst_r == pbarb_pkg::PB_PARK) |-> $past(!UPSTREAM_GNT_N_I))
    else $error("Start from park without grant last cycle");

  // ************************************************************
  // Secondary arbiter checks
  // ************************************************************
  // Parking must hold steady, or an idle bus would see grants wander

  AST_PARK_HOLD: assert property (@(posedge CLOCK_I) disable iff (RST_I || DOWNSTREAM_RST_I)
    (gnt_r != '0 && rq == '0 && !timeout && !park_bridge) |=> gnt_r == $past(gnt_r))
    else $error("Parked grant moved without a request");

  AST_FORCE_PARK: assert property (@(posedge CLOCK_I) disable iff (RST_I || DOWNSTREAM_RST_I)
    (park_bridge && !others && gnt_r == bridge_oh) |=> gnt_r == bridge_oh)
    else $error("Forced park left the bridge");

  AST_ARB_OFF: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    arb_off |-> (DOWNSTREAM_GNT_OE_O == 4'h0 && !DOWNSTREAM_BRIDGE_GNT_O))
    else $error("Grant driven with arbiter disabled");

  AST_PREEMPT_OFF: assert property (@(posedge CLOCK_I) disable iff (RST_I || DOWNSTREAM_RST_I)
    (!preempt_en && others && holder_req && !timeout && !park_bridge && gnt_r != '0)
    |=> gnt_r == $past(gnt_r))
    else $error("Holder preempted with preemption off");

  // Busy-bus swap is the only way one grant may replace another directly
  COV_SWAP_BUSY: cover property (@(posedge CLOCK_I) disable iff (RST_I)
    sbusy && gnt_r != '0 && gnt_nxt != '0 && gnt_nxt != gnt_r);
  COV_START: cover property (@(posedge CLOCK_I) disable iff (RST_I) UP_START_O);
  COV_PARK: cover property (@(posedge CLOCK_I) disable iff (RST_I) UPSTREAM_PARITY_OE_O);
  COV_PREEMPT: cover property (@(posedge CLOCK_I) disable iff (RST_I) preempt && sbusy);
  COV_TIMEOUT: cover property (@(posedge CLOCK_I) disable iff (RST_I) timeout);
endmodule : pbarb_top
`default_nettype wire

// ---- test/pbarb_far_model.sv ----
/*
  Far-side model: primary arbiter and four secondary masters.
  Assumes the bridge clock; the bench sets park, use and requests.
*/
`timescale 1ns/100ps
`default_nettype none
module pbarb_far_model (
  // Clock
  input wire logic clk_i,
  // Primary arbiter
  input wire logic req_n_i,
  input wire logic frame_n_i,
  input wire logic park_i,
  output logic gnt_n_o,
  output logic idle_o,
  // Secondary masters
  input wire logic use_i,
  input wire logic [3:0] m_req_n_i,
  input wire logic [3:0] gnt_n_i,
  output logic s_frame_n_o,
  output logic downstream_initiator_ready_n_n_o
);
  // *****
  // Grant one clock after request; busy for one clock after a frame
  // *****
  always_ff @(posedge clk_i) begin
    gnt_n_o <= req_n_i & ~park_i;
    idle_o <= frame_n_i;
    s_frame_n_o <= ~(use_i & |(~gnt_n_i & ~m_req_n_i));
    downstream_initiator_ready_n_n_o <= s_frame_n_o;
  end
endmodule : pbarb_far_model
`default_nettype wire

// ---- test/tb_top.sv ----
/*
  Bench: config access, primary request and parking, secondary arbiter.
  Assumes the package and the far-side model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, wr = 0, pend = 0, qd = 0, term = 0, park = 0;
  logic srst = 0, breq = 0, use_m = 0, start, gnt_n, idle, req_n, frame_n;
  logic ad_oe, cbe_oe, par_oe, sframe, sirdy, bgnt;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] mreq = 4'hF, sg, soe;
  wire [3:0] sgnt = sg | ~soe;
  int checks = 0, err_total = 0, last_n = 0;
  always #(pbarb_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  pbarb_top DUT (.CLOCK_I(clk), .RST_I(rst), .CFG_WR_I(wr), .CFG_ADDR_I(addr),
    .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .UP_PENDING_I(pend),
    .UP_QUEUED_I(qd), .UP_TERM_I(term), .UP_START_O(start),
    .UPSTREAM_GNT_N_I(gnt_n), .UPSTREAM_BUS_IDLE_I(idle),
    .UPSTREAM_REQ_N_O(req_n), .UPSTREAM_FRAME_N_O(frame_n),
    .UPSTREAM_AD_OE_O(ad_oe), .UPSTREAM_CMD_BYTE_EN_OE_O(cbe_oe),
    .UPSTREAM_PARITY_OE_O(par_oe), .DOWNSTREAM_RST_I(srst),
    .DOWNSTREAM_REQ_N_I(mreq), .DOWNSTREAM_BRIDGE_REQ_I(breq),
    .DOWNSTREAM_FRAME_N_I(sframe), .DOWNSTREAM_INITIATOR_READY_N_I(sirdy),
    .DOWNSTREAM_GNT_N_O(sg), .DOWNSTREAM_GNT_OE_O(soe),
    .DOWNSTREAM_BRIDGE_GNT_O(bgnt));
  pbarb_far_model far (.clk_i(clk), .req_n_i(req_n), .frame_n_i(frame_n),
    .park_i(park), .gnt_n_o(gnt_n), .idle_o(idle), .use_i(use_m),
    .m_req_n_i(mreq), .gnt_n_i(sgnt), .s_frame_n_o(sframe), .downstream_initiator_ready_n_n_o(sirdy));
  // *****
  // Access and check tasks
  // *****
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic print_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    tick();
    wr = 0;
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] e);
    addr = a;
    tick();
    chk(rdata, e, "read");
  endtask : cfg_rd
  // Slow waits end the run instead of hanging
  function automatic logic seen(input int k);
    case (k)
      0: seen = start;
      1: seen = ad_oe;
      2: seen = bgnt;
      default: seen = (k < 7) ? ~sgnt[2'(k - 3)] : sgnt[2'(k - 7)];
    endcase
  endfunction : seen
  task automatic wait_for(input int k, input int lim);
    last_n = 0;
    while (seen(k) !== 1'b1 && last_n < lim) begin
      tick();
      last_n++;
    end
    if (last_n == lim) begin
      err_total++;
      $display("BAD %0t wait %0d", $time, k);
      print_verdict();
    end
  endtask : wait_for
  // *****
  // Main sequence
  // *****
  initial begin
    tick(16);
    rst = 0;
    tick();
    cfg_rd(8'h48, 32'h0);
    cfg_rd(8'h4C, 32'hF000_0000);
    cfg_rd(8'h50, 32'h0);
    chk(bgnt, 1'b1, "bridge park");
    cfg_wr(8'h4C, 32'h0000_0007);
    cfg_rd(8'h4C, 32'h0000_0007);
    cfg_wr(8'h4C, 32'hF000_0002);
    pend = 1;
    tick(3);
    chk(req_n, 1'b1, "early req");
    qd = 1;
    tick();
    chk(req_n, 1'b0, "req");
    wait_for(0, 8);
    tick();
    term = 1;
    tick();
    term = 0;
    chk(req_n, 1'b1, "backoff 1");
    tick();
    chk(req_n, 1'b1, "backoff 2");
    tick();
    chk(req_n, 1'b0, "req again");
    pend = 0;
    qd = 0;
    tick(4);
    park = 1;
    wait_for(1, 8);
    chk(cbe_oe, 1'b1, "cbe park");
    chk(par_oe, 1'b0, "par early");
    tick();
    chk(par_oe, 1'b1, "par late");
    park = 0;
    tick(2);
    chk(ad_oe, 1'b0, "release");
    mreq = 4'hE;
    tick();
    chk({bgnt, sgnt}, 32'h0000_000F, "gap");
    wait_for(3, 8);
    mreq = 4'hF;
    wait_for(7, 30);
    chk(last_n inside {[15:17]}, 1'b1, "idle timeout");
    use_m = 1;
    mreq = 4'hD;
    wait_for(4, 24);
    tick(2);
    mreq = 4'h9;
    wait_for(8, 12);
    use_m = 0;
    mreq = 4'hF;
    cfg_wr(8'h48, 32'h0000_0002);
    wait_for(2, 24);
    cfg_wr(8'h48, 32'h0000_0001);
    tick(2);
    chk(soe, 4'h0, "disabled");
    cfg_wr(8'h48, 32'h0);
    tick(2);
    chk(soe, 4'hF, "enabled");
    cfg_wr(8'h48, 32'h0000_0800);
    mreq = 4'h9;
    wait_for(5, 8);
    chk(sgnt[1], 1'b1, "low level waits");
    mreq = 4'hF;
    srst = 1;
    #1;
    chk(soe, 4'h0, "sec reset");
    srst = 0;
    tick(2);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
